// File: design/pin_filter.sv
// timer pin synchroniser with edge detection
`include "reload_timer_cfg.svh"

module pin_filter (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic pinIn,
  tick_if.filter ev
);

  reload_timer_pkg::pin_filter_state_t state_reg;
  reload_timer_pkg::pin_filter_state_t state_next;
  logic agree;

  // ----------------------------------------------------------
  // next state
  // ----------------------------------------------------------
  // a change counts only once stages two and three agree
  always_comb begin
    state_next = state_reg;
    state_next.pinSync = {state_reg.pinSync[1:0], pinIn};
    agree = (state_reg.pinSync[2] == state_reg.pinSync[1]);
    if (agree) begin
      state_next.pinLevel = state_reg.pinSync[2];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // edges are one-cycle pulses of the filtered level
  assign ev.extPinLevel = state_reg.pinLevel;
  assign ev.risePulse = state_next.pinLevel & ~state_reg.pinLevel;
  assign ev.fallPulse = ~state_next.pinLevel & state_reg.pinLevel;

endmodule

// File: design/reload_timer_baud_edge.sv
// 16-bit auto-reload timer with baud, compare and edge trigger modes
//
// Function
// RULE1: data bytes load reload, read count
// RULE2: run increments; rollover sets flag, reloads
// RULE3: overflow one count after reaching all ones
// RULE4: overflow raises interrupt when enabled
// RULE5: software accesses high byte before low
// RULE6: stopped writes load reload and count
// RULE7: running writes change only reload value
// RULE8: two-bit mode field, 01 is baud
// RULE9: modes: reload, baud, rising, falling trigger
// RULE10: source select counts pin clock or system
// RULE11: prescaler divides by 1, 8, 64, 256
// RULE12: compare enable: toggle or retrigger allowance
// RULE13: pin toggles at each overflow, system clock
// RULE14: baud overflow reloads and raises interrupt
// RULE15: baud is tick rate over sixteen, reload
// RULE16: baud compare gives half-baud square wave; here the pin toggles each overflow, a wave at eight times baudTick
// RULE17: edge modes force system clock source
// RULE18: run arms; counting starts on edge
// RULE19: edge overflow reloads then waits trigger
// RULE20: without retrigger, edges during count ignored
// RULE21: retrigger edge reloads, restarts, no interrupt
// RULE22: run enable does not clear counter
// RULE23: stop timer before baud data access
// RULE24: external pin slower than half clock
// RULE25: flag cleared by hardware or software
`include "reload_timer_cfg.svh"

module reload_timer_baud_edge (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic run_enable,
  input wire logic [1:0] mode_field,
  input wire logic [1:0] prescale_select,
  input wire logic clock_source_select,
  input wire logic compare_retrigger_enable,
  input wire logic timer_irq_enable,
  input wire logic highByteWrite,
  input wire logic lowByteWrite,
  input wire logic [7:0] writeData,
  input wire logic highByteRead,
  input wire logic lowByteRead,
  input wire logic flagClearWrite,
  input wire logic irqAck,
  input wire logic timer_io_pin_in,
  output logic [7:0] readData,
  output logic overflow_flag,
  output logic timerIrq,
  output logic timer_io_pin_out,
  output logic timer_io_pin_oe,
  output logic baudTick,
  output logic [15:0] countValue
);

  tick_if ev ();

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] reload;
    logic [7:0] highLatch;
    logic [7:0] readLow;
    logic [7:0] readData;
    logic flag;
    logic pinOut;
    logic [3:0] baudDiv;
    logic baudTick;
    reload_timer_pkg::trig_state_t trig;
  } timer_state_t;

  timer_state_t state_reg;
  timer_state_t state_next;
  logic edgeMode;
  logic useExtClock;
  logic trigEdge;
  logic countNow;
  logic overflowNow;
  logic [15:0] loadValue;

  // ----------------------------------------------------------
  // tick source and trigger edge selection
  // ----------------------------------------------------------
  // edge modes ignore the source select bit
  assign edgeMode = mode_field[1]; // RULE8 RULE9
  assign useExtClock = clock_source_select & ~edgeMode; // RULE10 RULE17
  assign trigEdge = (mode_field == `MODE_RISE) ? ev.risePulse :
                    ev.fallPulse; // RULE9

  timer_prescaler u_prescaler (
    .sys_clk(sys_clk),
    .reset(reset),
    .runEnable(run_enable),
    .useExtClock(useExtClock),
    .extRise(ev.risePulse),
    .prescaleSelect(prescale_select),
    .tk(ev.prescaler)
  );

  pin_filter u_pin_filter (
    .sys_clk(sys_clk),
    .reset(reset),
    .pinIn(timer_io_pin_in),
    .ev(ev.filter)
  );

  // ----------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.baudTick = 1'b0;
    loadValue = {state_reg.highLatch, writeData};
    // only the TRIG_COUNTING part of edge modes counts, not TRIG_ARMED
    countNow = ev.countTick & run_enable &
               (~edgeMode ||
                state_reg.trig == reload_timer_pkg::TRIG_COUNTING);
    overflowNow = countNow && state_reg.count == `COUNT_MAX; // RULE3

    // count, overflow and reload
    if (countNow) begin
      if (overflowNow) begin
        state_next.count = state_reg.reload; // RULE2
      end else begin
        state_next.count = state_reg.count + 16'h0001; // RULE2
      end
    end

    // edge trigger sequencing
    case (state_reg.trig)
      reload_timer_pkg::TRIG_IDLE: begin
        if (run_enable && edgeMode) begin
          state_next.trig = reload_timer_pkg::TRIG_ARMED; // RULE18
        end
      end
      reload_timer_pkg::TRIG_ARMED: begin
        if (trigEdge) begin
          state_next.trig = reload_timer_pkg::TRIG_COUNTING; // RULE18
        end
      end
      reload_timer_pkg::TRIG_COUNTING: begin
        if (overflowNow) begin
          state_next.trig = reload_timer_pkg::TRIG_ARMED; // RULE19
        end else if (trigEdge && compare_retrigger_enable) begin
          state_next.count = state_reg.reload; // RULE21
        end
        // with retrigger off, edges fall through unused: RULE20
      end
      default: begin
        state_next.trig = reload_timer_pkg::TRIG_IDLE;
      end
    endcase
    if (!run_enable || !edgeMode) begin
      state_next.trig = reload_timer_pkg::TRIG_IDLE;
    end

    // high byte is held until the low byte completes the word
    if (highByteWrite) begin
      state_next.highLatch = writeData; // RULE5
    end
    if (lowByteWrite) begin
      state_next.reload = loadValue; // RULE1 RULE7
      if (!run_enable) begin
        state_next.count = loadValue; // RULE6
      end
    end

    // reading the high byte snapshots the low byte for consistency
    if (highByteRead) begin
      state_next.readData = state_reg.count[15:8]; // RULE1
      state_next.readLow = state_reg.count[7:0]; // RULE5
    end else if (lowByteRead) begin
      state_next.readData = state_reg.readLow;
    end

    // software clear loses to a same-cycle overflow
    if (flagClearWrite || irqAck) begin
      state_next.flag = 1'b0; // RULE25
    end
    if (overflowNow) begin
      state_next.flag = 1'b1; // RULE2 RULE14
    end

    // compare toggle needs the system clock source
    if (overflowNow && compare_retrigger_enable && !edgeMode &&
        !clock_source_select) begin
      state_next.pinOut = ~state_reg.pinOut; // RULE13 RULE16
    end

    // baud clock is overflow rate divided by sixteen
    if (overflowNow && mode_field == `MODE_BAUD) begin
      state_next.baudDiv = state_reg.baudDiv + 4'h1; // RULE15
      if (state_reg.baudDiv == `BAUD_DIV_MASK) begin
        state_next.baudTick = 1'b1; // RULE15
      end
    end
  end

  // ----------------------------------------------------------
  // state register
  // ----------------------------------------------------------
  // run enable never touches the count here, so no clear on start
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next; // RULE22
    end
  end

  // ----------------------------------------------------------
  // outputs
  // ----------------------------------------------------------
  assign readData = state_reg.readData;
  assign overflow_flag = state_reg.flag;
  assign timerIrq = state_reg.flag & timer_irq_enable; // RULE4 RULE14
  assign timer_io_pin_out = state_reg.pinOut;
  // pin drives only in the toggle modes with compare on
  assign timer_io_pin_oe = compare_retrigger_enable & ~edgeMode &
                           ~clock_source_select; // RULE12
  assign baudTick = state_reg.baudTick;
  assign countValue = state_reg.count;

endmodule

// File: design/reload_timer_cfg.svh
// constants of the reload timer: field codes, widths and timing counts
`ifndef RELOAD_TIMER_CFG_SVH
`define RELOAD_TIMER_CFG_SVH

// ------------------------------------------------------------
// field codes
// ------------------------------------------------------------
`define MODE_RELOAD 2'h0
`define MODE_BAUD 2'h1
`define MODE_RISE 2'h2
`define MODE_FALL 2'h3
`define PRESCALE_DIV1 2'h0
`define PRESCALE_DIV8 2'h1
`define PRESCALE_DIV64 2'h2
`define PRESCALE_DIV256 2'h3

// ------------------------------------------------------------
// reset values and widths
// ------------------------------------------------------------
`define COUNT_RESET 16'h0000
`define COUNT_MAX 16'hFFFF
`define DIV_WIDTH 8
`define DIV_MASK_1 8'h00
`define DIV_MASK_8 8'h07
`define DIV_MASK_64 8'h3F
`define DIV_MASK_256 8'hFF
`define BAUD_DIV_MASK 4'hF

`endif

// File: design/reload_timer_pkg.sv
// types shared by the reload timer modules
package reload_timer_pkg;

  typedef enum logic [1:0] {
    TRIG_IDLE,
    TRIG_ARMED,
    TRIG_COUNTING
  } trig_state_t;

  typedef struct packed {
    logic [7:0] divCount;
  } prescale_state_t;

  typedef struct packed {
    logic [2:0] pinSync;
    logic pinLevel;
  } pin_filter_state_t;

endpackage

// File: design/tick_if.sv
// count tick and pin edge events passed between the timer modules
interface tick_if;
  logic extPinLevel;
  logic risePulse;
  logic fallPulse;
  logic countTick;

  modport filter (
    output extPinLevel,
    output risePulse,
    output fallPulse
  );
  modport prescaler (
    output countTick
  );
  modport core (
    input extPinLevel,
    input risePulse,
    input fallPulse,
    input countTick
  );
endinterface

// File: design/timer_prescaler.sv
// count tick generator: source select and 1/8/64/256 prescaler
`include "reload_timer_cfg.svh"

module timer_prescaler (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic runEnable,
  input wire logic useExtClock,
  input wire logic extRise,
  input wire logic [1:0] prescaleSelect,
  tick_if.prescaler tk
);

  reload_timer_pkg::prescale_state_t state_reg;
  reload_timer_pkg::prescale_state_t state_next;
  logic srcTick;
  logic [7:0] divMask;

  // decode of the prescale code into a terminal mask
  function automatic logic [7:0] maskOf(input logic [1:0] sel);
    if (sel == `PRESCALE_DIV8) begin
      maskOf = `DIV_MASK_8;
    end else if (sel == `PRESCALE_DIV64) begin
      maskOf = `DIV_MASK_64;
    end else if (sel == `PRESCALE_DIV256) begin
      maskOf = `DIV_MASK_256;
    end else begin
      maskOf = `DIV_MASK_1;
    end
  endfunction

  // ----------------------------------------------------------
  // divider
  // ----------------------------------------------------------
  // divider clears while stopped so a restart begins a full period
  always_comb begin
    state_next = state_reg;
    srcTick = useExtClock ? extRise : 1'b1; // RULE10 RULE24
    divMask = maskOf(prescaleSelect);
    tk.countTick = 1'b0;
    if (!runEnable) begin
      state_next.divCount = 8'h00;
    end else if (srcTick) begin
      if ((state_reg.divCount & divMask) == divMask) begin
        state_next.divCount = 8'h00;
        tk.countTick = 1'b1; // RULE11
      end else begin
        state_next.divCount = state_reg.divCount + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

// File: tb/pin_model.sv
// timer pin: trigger level, slow external clock or toggle output
module pin_model (
  input wire logic sys_clk,
  input wire logic clkOn,
  input wire logic level,
  input wire logic oe,
  input wire logic drv,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] div_reg = 3'h0;
  // an eighth of sys_clk keeps well under half the rate
  always @(posedge sys_clk) begin
    div_reg <= div_reg + 3'h1;
  end
  assign pin = oe ? drv : (clkOn ? div_reg[2] : level);
endmodule

// File: tb/reload_timer_assertions.sv
// port-level checks of the reload timer
module reload_timer_checker (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic run_enable,
  input wire logic [1:0] mode_field,
  input wire logic timer_irq_enable,
  input wire logic lowByteWrite,
  input wire logic highByteWrite,
  input wire logic [7:0] writeData,
  input wire logic highByteRead,
  input wire logic lowByteRead,
  input wire logic [7:0] readData,
  input wire logic overflow_flag,
  input wire logic timerIrq,
  input wire logic timer_io_pin_out,
  input wire logic timer_io_pin_oe,
  input wire logic baudTick,
  input wire logic [15:0] countValue
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [15:0] cntPrev_reg, cntPrev2_reg;
  logic [7:0] hiSeen_reg;
  logic runPrev_reg, edgePrev_reg, oePrev_reg, wrap;
  // history flops; no reset needed, checks are off until reset drops
  always_ff @(posedge sys_clk) begin
    cntPrev_reg <= countValue;
    cntPrev2_reg <= cntPrev_reg;
    runPrev_reg <= run_enable;
    edgePrev_reg <= mode_field[1];
    oePrev_reg <= timer_io_pin_oe;
    hiSeen_reg <= highByteWrite ? writeData : hiSeen_reg;
  end
  // a rollover out of all ones while running
  assign wrap = runPrev_reg && cntPrev_reg == 16'hFFFF
    && countValue != 16'hFFFF;
  property p_irq;
    timerIrq == (overflow_flag && timer_irq_enable);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_ovf;
    wrap |-> overflow_flag;
  endproperty
  a_ovf: assert property (p_ovf) else $error("no flag");
  property p_step;
    runPrev_reg && !edgePrev_reg && cntPrev_reg != 16'hFFFF
      && countValue != cntPrev_reg |-> countValue == cntPrev_reg + 16'h1;
  endproperty
  a_step: assert property (p_step) else $error("bad step");
  property p_wr;
    !run_enable && lowByteWrite |=>
      countValue == {$past(hiSeen_reg), $past(writeData)};
  endproperty
  a_wr: assert property (p_wr) else $error("bad load");
  property p_rdh;
    highByteRead |=> readData == cntPrev_reg[15:8];
  endproperty
  a_rdh: assert property (p_rdh) else $error("bad high");
  property p_rdl;
    highByteRead ##1 lowByteRead |=> readData == cntPrev2_reg[7:0];
  endproperty
  a_rdl: assert property (p_rdl) else $error("bad low");
  property p_tog;
    wrap && oePrev_reg |-> timer_io_pin_out != $past(timer_io_pin_out);
  endproperty
  a_tog: assert property (p_tog) else $error("no toggle");
  property p_hold;
    wrap && mode_field[1] |=> $stable(countValue) [*3];
  endproperty
  a_hold: assert property (p_hold) else $error("no hold");
  c_wrap: cover property (wrap);
  c_baud: cover property (baudTick);
  c_read: cover property (highByteRead ##1 lowByteRead);
endmodule

bind reload_timer_baud_edge reload_timer_checker checker_i (.sys_clk,
  .reset, .run_enable, .mode_field, .timer_irq_enable, .lowByteWrite,
  .highByteWrite, .writeData, .highByteRead, .lowByteRead, .readData,
  .overflow_flag, .timerIrq, .timer_io_pin_out, .timer_io_pin_oe,
  .baudTick, .countValue);

// File: tb/test_reload_timer_baud_edge.sv
// self-checking bench for the reload timer
`include "reload_timer_cfg.svh"
module test_reload_timer_baud_edge;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'h0, reset = 1'h1, run_enable = 1'h0, clkOn = 1'h0;
  logic clock_source_select = 1'h0, compare_retrigger_enable = 1'h0;
  logic timer_irq_enable = 1'h0, highByteWrite = 1'h0, level = 1'h0;
  logic lowByteWrite = 1'h0, highByteRead = 1'h0, lowByteRead = 1'h0;
  logic flagClearWrite = 1'h0, irqAck = 1'h0;
  logic [1:0] mode_field = 2'h0, prescale_select = 2'h0;
  logic [7:0] writeData = 8'h00, readData;
  logic overflow_flag, timerIrq, timer_io_pin_out, timer_io_pin_oe;
  logic baudTick, timer_io_pin_in;
  logic [15:0] countValue, v, r;
  logic [31:0] seed = 32'h958C428A;
  int errors = 0, tests_run = 0, n, k, reloadM;
  always #50 sys_clk = ~sys_clk;
  reload_timer_baud_edge DUT (.sys_clk, .reset, .run_enable, .mode_field,
    .prescale_select, .clock_source_select, .compare_retrigger_enable,
    .timer_irq_enable, .highByteWrite, .lowByteWrite, .writeData,
    .highByteRead, .lowByteRead, .flagClearWrite, .irqAck, .timer_io_pin_in,
    .readData, .overflow_flag, .timerIrq, .timer_io_pin_out,
    .timer_io_pin_oe, .baudTick, .countValue);
  pin_model pm (.sys_clk, .clkOn, .level, .oe(timer_io_pin_oe),
    .drv(timer_io_pin_out), .pin(timer_io_pin_in));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // inputs always move one step after the rising edge
  task automatic cyc(int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr16(logic [15:0] x);
    {highByteWrite, writeData} = {1'h1, x[15:8]};
    cyc(1);
    {highByteWrite, lowByteWrite, writeData} = {2'h1, x[7:0]};
    cyc(1);
    lowByteWrite = 1'h0;
  endtask
  task automatic rd16(output logic [15:0] x);
    highByteRead = 1'h1;
    cyc(1);
    {highByteRead, lowByteRead, x[15:8]} = {2'h1, readData};
    cyc(1);
    {lowByteRead, x[7:0]} = {1'h0, readData};
  endtask
  task automatic waitFlag(output int c);
    c = 0;
    while (overflow_flag !== 1'h1 && c < 3000) begin
      cyc(1);
      c++;
    end
  endtask
  // stop, clear the flag, load count and reload, then run
  task automatic start(logic [1:0] m, logic [1:0] p, logic [15:0] x);
    {run_enable, mode_field, prescale_select} = {1'h0, m, p};
    flagClearWrite = 1'h1;
    cyc(1);
    flagClearWrite = 1'h0;
    wr16(x);
    reloadM = x;
    chk(countValue, x);
    chk(overflow_flag, 16'h0);
    run_enable = 1'h1;
  endtask
  task automatic close_out();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // watchdog: the whole sequence needs little more than a thousand cycles
  initial begin
    cyc(8000);
    errors++;
    close_out();
  end
  initial begin
    cyc(2);
    reset = 1'h0;
    chk(countValue, 16'h0);
    r = rnd();
    wr16(r);
    rd16(v);
    chk(v, r);
    timer_irq_enable = 1'h1;
    for (k = 0; k < 4; k++) begin
      start(`MODE_RELOAD, k[1:0], 16'hFFFE);
      waitFlag(n);
      // ratios are 1, 8, 64 and 256: the last is not a power of eight
      reloadM = (k == 3) ? 256 : (1 << 3 * k);
      chk(n > reloadM && n <= 2 * reloadM + 3, 16'h1);
      reloadM = 16'hFFFE;
      chk(countValue, reloadM[15:0]);
      chk(timerIrq, 16'h1);
    end
    compare_retrigger_enable = 1'h1;
    start(`MODE_RELOAD, `PRESCALE_DIV1, 16'hFFF0);
    r = rnd() & 16'h7FFF;
    wr16(r);
    chk(countValue[15:4], 16'hFFF);
    v[0] = timer_io_pin_out;
    waitFlag(n);
    chk(countValue, r);
    chk(timer_io_pin_out, !v[0]);
    chk(timer_io_pin_oe, 16'h1);
    compare_retrigger_enable = 1'h0;
    {clock_source_select, clkOn} = 2'h3;
    start(`MODE_RELOAD, `PRESCALE_DIV1, 16'hFFFE);
    waitFlag(n);
    chk(n > 8 && n < 28, 16'h1);
    // data bytes are only touched with the timer stopped
    {clock_source_select, clkOn, timer_irq_enable} = 3'h0;
    start(`MODE_BAUD, `PRESCALE_DIV1, 16'hFFFF);
    n = 0;
    repeat (160) begin
      cyc(1);
      n += baudTick;
    end
    chk(n >= 9 && n <= 10, 16'h1);
    chk({overflow_flag, timerIrq}, 16'h2);
    // edge modes: source select set on purpose, it must be ignored
    for (k = 2; k < 4; k++) begin
      level = (k == 3);
      compare_retrigger_enable = (k == 3);
      clock_source_select = 1'h1;
      start(k[1:0], `PRESCALE_DIV1, 16'hFFC0);
      cyc(20);
      chk(countValue, 16'hFFC0);
      level = !level;
      cyc(10);
      chk(countValue != 16'hFFC0, 16'h1);
      level = !level;
      cyc(6);
      level = !level;
      cyc(8);
      chk(countValue - 16'hFFC0 < 16, k == 3);
      chk(overflow_flag, 16'h0);
      waitFlag(n);
      cyc(10);
      chk(countValue, reloadM[15:0]);
    end
    close_out();
  end
endmodule
